// *** mcrm_map.vh ***
// constants for the controller register map block
// Summary of operation
// - core register set less second and fourth ports, size register at top
// - three test-reserved slots, no register there
// - first port reads stored value, overwritten by bus
// - second and fourth port registers absent
// - third port register supplies upper address byte
// - control window at 7F00h via data pointer
// - offset F1h split into two directional registers
// - indexed registers not decoded from host I/O
`ifndef MCRM_MAP_VH
`define MCRM_MAP_VH
// core special function register locations
`define MCRM_SFR_FIRST_PORT 8'h80
`define MCRM_SFR_STACK_PTR 8'h81
`define MCRM_SFR_DATA_POINTER_LOW 8'h82
`define MCRM_SFR_DATA_POINTER_HIGH 8'h83
`define MCRM_SFR_TEST_A 8'h84
`define MCRM_SFR_TEST_B 8'h85
`define MCRM_SFR_TEST_C 8'h86
`define MCRM_SFR_POWER_CTRL 8'h87
`define MCRM_SFR_TIMER_CTRL 8'h88
`define MCRM_SFR_TIMER_MODE 8'h89
`define MCRM_SFR_TIMER0_LOW 8'h8A
`define MCRM_SFR_TIMER1_LOW 8'h8B
`define MCRM_SFR_TIMER0_HIGH 8'h8C
`define MCRM_SFR_TIMER1_HIGH 8'h8D
`define MCRM_SFR_SECOND_PORT 8'h90
`define MCRM_SFR_SERIAL_CTRL 8'h98
`define MCRM_SFR_SERIAL_BUF 8'h99
`define MCRM_SFR_THIRD_PORT 8'hA0
`define MCRM_SFR_INT_ENABLE 8'hA8
`define MCRM_SFR_FOURTH_PORT 8'hB0
`define MCRM_SFR_INT_PRIORITY 8'hB8
`define MCRM_SFR_STATUS_WORD 8'hD0
`define MCRM_SFR_ACCUM 8'hE0
`define MCRM_SFR_B_REG 8'hF0
`define MCRM_SFR_MEM_SIZE 8'hFF
// control window
`define MCRM_WINDOW_PAGE 8'h7F
`define MCRM_OFF_HOST_DATA 8'hF1
`define MCRM_OFF_HOST_STATUS 8'hF2
`define MCRM_OFF_AUX_TIMER 8'hF3
`define MCRM_OFF_CONFIG0 8'hF4
`define MCRM_OFF_CMOS_CTRL 8'hF5
`define MCRM_OFF_CMOS_LO_IDX 8'hF6
`define MCRM_OFF_CMOS_LO_VAL 8'hF7
`define MCRM_OFF_CMOS_HI_IDX 8'hF8
`define MCRM_OFF_CMOS_HI_VAL 8'hF9
// host I/O addresses
`define MCRM_IO_KBD_DATA 16'h0060
`define MCRM_IO_KBD_CMD 16'h0064
`define MCRM_IO_CMOS_IDX1 16'h0070
`define MCRM_IO_CMOS_VAL1 16'h0071
`define MCRM_IO_CMOS_IDX2 16'h0074
`define MCRM_IO_CMOS_VAL2 16'h0076
// reset values
`define MCRM_RST_ZERO 8'h00
`define MCRM_RST_CMOS_CTRL 8'h80
`define MCRM_RST_MEM_SIZE 8'h00
`endif

// *** mcrm_sfr_cell.v ***
// one plain core special function register with write and reset
`timescale 1ns/100ps
`default_nettype none
module mcrm_sfr_cell #(
    parameter [7:0] RESET_VALUE = 8'h00
) (
    input wire clk,
    input wire reset,
    input wire wr,
    input wire [7:0] din,
    output reg [7:0] q_r
);
    // store on write, reset to constant
    always @(posedge clk) begin
        if (reset) begin
            q_r <= RESET_VALUE;
        end else if (wr) begin
            q_r <= din;
        end
    end
endmodule
`default_nettype wire

// *** mcrm_register_map.v ***
// register bank and address decode for the embedded controller core
`timescale 1ns/100ps
`default_nettype none
`include "mcrm_map.vh"
module mcrm_register_map (
    input wire clk,
    input wire reset,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata_r,
    input wire xd_wr,
    input wire xd_rd,
    input wire xd_use_data_pointer,
    input wire [7:0] xd_low_addr,
    input wire [7:0] xd_wdata,
    output reg [7:0] xd_rdata_r,
    output reg xd_hit_r,
    input wire ext_bus_load,
    input wire [7:0] ext_bus_byte,
    input wire io_wr,
    input wire io_rd,
    input wire [15:0] io_addr,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata_r,
    output reg io_hit_r,
    output reg host_data_full_r,
    output reg [7:0] aux_timer_control_r,
    output reg [7:0] configuration_zero_r,
    output reg [7:0] clock_cmos_access_control_r
);
    // ==========================================================
    // decode helpers
    // ==========================================================
    function is_test_slot;
        input [7:0] a;
        begin
            is_test_slot = (a == `MCRM_SFR_TEST_A) || (a == `MCRM_SFR_TEST_B) || (a == `MCRM_SFR_TEST_C);
        end
    endfunction

    // scratch-cell core registers, one cell per standard location except the ports at 80h, 90h and B0h
    localparam NCELL = 19;
    localparam [NCELL*8-1:0] CELL_ADDRS = {
        `MCRM_SFR_STACK_PTR, `MCRM_SFR_DATA_POINTER_LOW, `MCRM_SFR_DATA_POINTER_HIGH, `MCRM_SFR_POWER_CTRL,
        `MCRM_SFR_TIMER_CTRL, `MCRM_SFR_TIMER_MODE, `MCRM_SFR_TIMER0_LOW, `MCRM_SFR_TIMER1_LOW,
        `MCRM_SFR_TIMER0_HIGH, `MCRM_SFR_TIMER1_HIGH, `MCRM_SFR_SERIAL_CTRL, `MCRM_SFR_SERIAL_BUF,
        `MCRM_SFR_THIRD_PORT, `MCRM_SFR_INT_ENABLE, `MCRM_SFR_INT_PRIORITY, `MCRM_SFR_STATUS_WORD,
        `MCRM_SFR_ACCUM, `MCRM_SFR_B_REG, `MCRM_SFR_MEM_SIZE};

    wire [NCELL*8-1:0] cell_q;
    reg [7:0] first_port_register_r;

    // ==========================================================
    // core register cells
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < NCELL; gi = gi + 1) begin : g_cell
            // standard set less the ports at 80h, 90h and B0h, plus size register at the top row end
            mcrm_sfr_cell #(
                .RESET_VALUE((CELL_ADDRS[gi*8 +: 8] == `MCRM_SFR_MEM_SIZE) ? `MCRM_RST_MEM_SIZE : `MCRM_RST_ZERO)
            ) u_cell (
                .clk(clk),
                .reset(reset),
                .wr(sfr_wr && (sfr_addr == CELL_ADDRS[gi*8 +: 8])),
                .din(sfr_wdata),
                .q_r(cell_q[gi*8 +: 8])
            );
        end
    endgenerate

    // cell index lookup: third port is cell 6, pointer bytes 16 and 17
    wire [7:0] data_pointer_low = cell_q[17*8 +: 8];
    wire [7:0] third_port_register = cell_q[6*8 +: 8];

    // first port: stored value, overwritten by external cycles
    always @(posedge clk) begin
        if (reset) begin
            first_port_register_r <= `MCRM_RST_ZERO;
        end else if (ext_bus_load) begin
            first_port_register_r <= ext_bus_byte; // external cycle corrupts it
        end else if (sfr_wr && sfr_addr == `MCRM_SFR_FIRST_PORT) begin
            first_port_register_r <= sfr_wdata;
        end
    end

    // special function register read mux
    reg [7:0] sfr_rd_nxt;
    integer k;
    always @* begin
        sfr_rd_nxt = `MCRM_RST_ZERO;
        if (sfr_addr == `MCRM_SFR_FIRST_PORT) begin
            sfr_rd_nxt = first_port_register_r; // never samples pins
        end
        for (k = 0; k < NCELL; k = k + 1) begin
            if (sfr_addr == CELL_ADDRS[k*8 +: 8]) begin
                sfr_rd_nxt = cell_q[k*8 +: 8];
            end
        end
        // test slots and absent ports read zero, hold nothing
        if (is_test_slot(sfr_addr) || sfr_addr == `MCRM_SFR_SECOND_PORT || sfr_addr == `MCRM_SFR_FOURTH_PORT) begin
            sfr_rd_nxt = `MCRM_RST_ZERO;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            sfr_rdata_r <= `MCRM_RST_ZERO;
        end else if (sfr_rd) begin
            sfr_rdata_r <= sfr_rd_nxt;
        end
    end

    // ==========================================================
    // control window decode
    // ==========================================================
    // upper byte from pointer high or third port register
    wire [7:0] xd_page = xd_use_data_pointer ? cell_q[16*8 +: 8] : third_port_register;
    wire xd_in_window = (xd_page == `MCRM_WINDOW_PAGE);
    wire [7:0] xd_off = xd_use_data_pointer ? data_pointer_low : xd_low_addr;

    reg [7:0] host_to_core_data_r;
    reg [7:0] core_to_host_data_r;
    reg [7:0] host_interface_status_r;
    reg [7:0] cmos_low_bank_index_r;
    reg [7:0] cmos_low_bank_value_r;
    reg [7:0] cmos_high_bank_index_r;
    reg [7:0] cmos_high_bank_value_r;
    reg [7:0] host_cmos_index_first_r;
    reg [7:0] host_cmos_value_first_r;
    reg [7:0] host_cmos_index_second_r;
    reg [7:0] host_cmos_value_second_r;

    wire xw = xd_wr && xd_in_window;
    wire host_wr_kbd = io_wr && (io_addr == `MCRM_IO_KBD_DATA || io_addr == `MCRM_IO_KBD_CMD);

    // window registers and host-side writes, all reset on power-on
    always @(posedge clk) begin
        if (reset) begin
            host_to_core_data_r <= `MCRM_RST_ZERO;
            core_to_host_data_r <= `MCRM_RST_ZERO;
            host_interface_status_r <= `MCRM_RST_ZERO;
            aux_timer_control_r <= `MCRM_RST_ZERO;
            configuration_zero_r <= `MCRM_RST_ZERO;
            clock_cmos_access_control_r <= `MCRM_RST_CMOS_CTRL;
            cmos_low_bank_index_r <= `MCRM_RST_ZERO;
            cmos_low_bank_value_r <= `MCRM_RST_ZERO;
            cmos_high_bank_index_r <= `MCRM_RST_ZERO;
            cmos_high_bank_value_r <= `MCRM_RST_ZERO;
            host_cmos_index_first_r <= `MCRM_RST_ZERO;
            host_cmos_value_first_r <= `MCRM_RST_ZERO;
            host_cmos_index_second_r <= `MCRM_RST_ZERO;
            host_cmos_value_second_r <= `MCRM_RST_ZERO;
            host_data_full_r <= 1'b0;
        end else begin
            // host writes to 60h or 64h land in core-readable half
            if (host_wr_kbd) begin
                host_to_core_data_r <= io_wdata;
            end
            // core read of F1h drains it; a same-cycle host write wins
            if (host_wr_kbd) begin
                host_data_full_r <= 1'b1;
            end else if (xd_rd && xd_in_window && xd_off == `MCRM_OFF_HOST_DATA) begin
                host_data_full_r <= 1'b0;
            end
            if (io_wr && io_addr == `MCRM_IO_CMOS_IDX1) host_cmos_index_first_r <= io_wdata;
            if (io_wr && io_addr == `MCRM_IO_CMOS_VAL1) host_cmos_value_first_r <= io_wdata;
            if (io_wr && io_addr == `MCRM_IO_CMOS_IDX2) host_cmos_index_second_r <= io_wdata;
            if (io_wr && io_addr == `MCRM_IO_CMOS_VAL2) host_cmos_value_second_r <= io_wdata;
            if (xw) begin
                case (xd_off)
                    `MCRM_OFF_HOST_DATA: core_to_host_data_r <= xd_wdata; // separate half
                    `MCRM_OFF_HOST_STATUS: host_interface_status_r <= xd_wdata;
                    `MCRM_OFF_AUX_TIMER: aux_timer_control_r <= xd_wdata;
                    `MCRM_OFF_CONFIG0: configuration_zero_r <= xd_wdata;
                    `MCRM_OFF_CMOS_CTRL: clock_cmos_access_control_r <= xd_wdata;
                    `MCRM_OFF_CMOS_LO_IDX: cmos_low_bank_index_r <= xd_wdata;
                    `MCRM_OFF_CMOS_LO_VAL: cmos_low_bank_value_r <= xd_wdata;
                    `MCRM_OFF_CMOS_HI_IDX: cmos_high_bank_index_r <= xd_wdata;
                    `MCRM_OFF_CMOS_HI_VAL: cmos_high_bank_value_r <= xd_wdata;
                    default: ;
                endcase
            end
        end
    end

    // core-side read mux of the window
    reg [7:0] xd_rd_nxt;
    reg xd_hit_nxt;
    always @* begin
        xd_hit_nxt = 1'b1;
        case (xd_off)
            `MCRM_OFF_HOST_DATA: xd_rd_nxt = host_to_core_data_r; // core reads host half
            `MCRM_OFF_HOST_STATUS: xd_rd_nxt = host_interface_status_r;
            `MCRM_OFF_AUX_TIMER: xd_rd_nxt = aux_timer_control_r;
            `MCRM_OFF_CONFIG0: xd_rd_nxt = configuration_zero_r;
            `MCRM_OFF_CMOS_CTRL: xd_rd_nxt = clock_cmos_access_control_r;
            `MCRM_OFF_CMOS_LO_IDX: xd_rd_nxt = cmos_low_bank_index_r;
            `MCRM_OFF_CMOS_LO_VAL: xd_rd_nxt = cmos_low_bank_value_r;
            `MCRM_OFF_CMOS_HI_IDX: xd_rd_nxt = cmos_high_bank_index_r;
            `MCRM_OFF_CMOS_HI_VAL: xd_rd_nxt = cmos_high_bank_value_r;
            default: begin
                xd_rd_nxt = `MCRM_RST_ZERO;
                xd_hit_nxt = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            xd_rdata_r <= `MCRM_RST_ZERO;
            xd_hit_r <= 1'b0;
        end else if (xd_rd || xd_wr) begin
            xd_rdata_r <= (xd_rd && xd_in_window) ? xd_rd_nxt : `MCRM_RST_ZERO;
            xd_hit_r <= xd_in_window && xd_hit_nxt;
        end
    end

    // ==========================================================
    // host I/O decode: direct addresses only, no indexed space
    // ==========================================================
    reg [7:0] io_rd_nxt;
    reg io_hit_nxt;
    always @* begin
        io_hit_nxt = 1'b1;
        case (io_addr)
            `MCRM_IO_KBD_DATA: io_rd_nxt = core_to_host_data_r; // host reads core half
            `MCRM_IO_KBD_CMD: io_rd_nxt = host_interface_status_r;
            `MCRM_IO_CMOS_IDX1: io_rd_nxt = host_cmos_index_first_r;
            `MCRM_IO_CMOS_VAL1: io_rd_nxt = host_cmos_value_first_r;
            `MCRM_IO_CMOS_IDX2: io_rd_nxt = host_cmos_index_second_r;
            `MCRM_IO_CMOS_VAL2: io_rd_nxt = host_cmos_value_second_r;
            default: begin
                io_rd_nxt = `MCRM_RST_ZERO; // indexed registers never hit here
                io_hit_nxt = 1'b0;
            end
        endcase
    end

    // answered next edge, no wait states
    always @(posedge clk) begin
        if (reset) begin
            io_rdata_r <= `MCRM_RST_ZERO;
            io_hit_r <= 1'b0;
        end else begin
            io_rdata_r <= io_rd ? io_rd_nxt : `MCRM_RST_ZERO;
            io_hit_r <= (io_rd || io_wr) && io_hit_nxt;
        end
    end
endmodule
`default_nettype wire

// *** mcrm_monitor.sv ***
// assertion checker for the register map ports
`timescale 1ns/100ps
`default_nettype none
module mcrm_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_rdata_r,
    input wire logic xd_rd,
    input wire logic xd_use_data_pointer,
    input wire logic [7:0] xd_low_addr,
    input wire logic [7:0] xd_rdata_r,
    input wire logic xd_hit_r,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire logic io_hit_r,
    input wire logic host_data_full_r,
    input wire logic [7:0] configuration_zero_r,
    input wire logic [7:0] clock_cmos_access_control_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // direct host decode, and a core read of the data slot that hit
    wire logic host_io = io_addr inside {16'h0060, 16'h0064, 16'h0070, 16'h0071, 16'h0074, 16'h0076};
    sequence core_drain_s;
        // pointer mode takes its offset from the pointer, which this checker cannot see
        xd_rd && !xd_use_data_pointer && !io_wr && xd_low_addr == 8'hF1 ##1 xd_hit_r;
    endsequence
    full_on_write_a: assert property (io_wr && io_addr inside {16'h0060, 16'h0064} |=> host_data_full_r)
        else $error("full flag not set");
    drain_clears_a: assert property (core_drain_s |-> !host_data_full_r) else $error("full flag kept");
    host_zero_wait_a: assert property (io_rd && host_io |=> io_hit_r) else $error("host read late");
    no_index_decode_a: assert property (io_rd && !host_io |=> !io_hit_r) else $error("stray host hit");
    absent_sfr_zero_a: assert property (sfr_rd && sfr_addr inside {8'h85, 8'h90, 8'hB0} |=> sfr_rdata_r == 8'h00)
        else $error("absent register read");
    sfr_data_holds_a: assert property (!sfr_rd |=> $stable(sfr_rdata_r)) else $error("read data moved");
    window_miss_zero_a: assert property (xd_rd ##1 !xd_hit_r |-> xd_rdata_r == 8'h00) else $error("miss data");
    reset_values_a: assert property ($fell(reset) |-> clock_cmos_access_control_r == 8'h80)
        else $error("bad reset value");
endmodule
bind mcrm_register_map mcrm_monitor u_mon (
    .clk(clk), .reset(reset), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_rdata_r(sfr_rdata_r),
    .xd_rd(xd_rd), .xd_use_data_pointer(xd_use_data_pointer), .xd_low_addr(xd_low_addr), .xd_rdata_r(xd_rdata_r),
    .xd_hit_r(xd_hit_r), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_hit_r(io_hit_r),
    .host_data_full_r(host_data_full_r), .configuration_zero_r(configuration_zero_r),
    .clock_cmos_access_control_r(clock_cmos_access_control_r)
);
`default_nettype wire

// *** mcrm_host_model.sv ***
// host I/O bus model for the keyboard and clock/CMOS ports
`timescale 1ns/100ps
`default_nettype none
module mcrm_host_model (
    input wire logic clk,
    output logic io_wr,
    output logic io_rd,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata_r,
    input wire logic io_hit_r
);
    // idle bus shows inverted values so a stale address never decodes by luck
    initial {io_wr, io_rd, io_addr, io_wdata} = {2'h0, 16'hFFFF, 8'hFF};
    // zero-wait cycle: request over one edge, registered answer taken after it
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] rd, output logic hit);
        @(negedge clk);
        {io_wr, io_rd, io_addr, io_wdata} = {wr, !wr, a, d};
        @(negedge clk);
        {io_wr, io_rd, io_addr, io_wdata} = {2'h0, ~a, ~d};
        {rd, hit} = {io_rdata_r, io_hit_r};
    endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the register map
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'h0, reset = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0, xd_wr = 1'h0, xd_rd = 1'h0;
    logic xd_use_data_pointer = 1'h0, ext_bus_load = 1'h0, io_wr, io_rd, io_hit_r, xd_hit_r, host_data_full_r, hit;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, xd_low_addr = 8'h00, xd_wdata = 8'h00, ext_bus_byte = 8'h00;
    logic [7:0] io_wdata, io_rdata_r, sfr_rdata_r, xd_rdata_r, got, aux_timer_control_r, configuration_zero_r;
    logic [7:0] clock_cmos_access_control_r;
    logic [15:0] io_addr;
    wire logic [7:0] rst_mix = clock_cmos_access_control_r ^ 8'h80 | configuration_zero_r | aux_timer_control_r;
    int miscompares = 0, n_checks = 0;
    typedef struct packed {logic [1:0] kind; logic [7:0] addr, wd, exp;} mcrm_row_t; // kind 0 core, 1 page, 2 pointer
    mcrm_row_t rows [11] = '{'{2'h0, 8'hA0, 8'h7F, 8'h7F}, '{2'h0, 8'h83, 8'h7F, 8'h7F},
        '{2'h0, 8'hFF, 8'hC3, 8'hC3}, '{2'h0, 8'h85, 8'h55, 8'h00}, '{2'h0, 8'h90, 8'h55, 8'h00},
        '{2'h0, 8'hB0, 8'h55, 8'h00}, '{2'h1, 8'hF3, 8'h3C, 8'h3C}, '{2'h1, 8'hF4, 8'hA5, 8'hA5},
        '{2'h2, 8'hF7, 8'h34, 8'h34}, '{2'h2, 8'hF9, 8'h78, 8'h78}, '{2'h2, 8'hF5, 8'h0F, 8'h0F}};
    // free-running 250 MHz clock
    always #2 clk = ~clk;
    mcrm_register_map uut (
        .clk(clk), .reset(reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .xd_wr(xd_wr), .xd_rd(xd_rd),
        .xd_use_data_pointer(xd_use_data_pointer), .xd_low_addr(xd_low_addr), .xd_wdata(xd_wdata),
        .xd_rdata_r(xd_rdata_r), .xd_hit_r(xd_hit_r), .ext_bus_load(ext_bus_load),
        .ext_bus_byte(ext_bus_byte), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .io_hit_r(io_hit_r),
        .host_data_full_r(host_data_full_r), .aux_timer_control_r(aux_timer_control_r),
        .configuration_zero_r(configuration_zero_r),
        .clock_cmos_access_control_r(clock_cmos_access_control_r)
    );
    mcrm_host_model u_host (
        .clk(clk), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata_r(io_rdata_r), .io_hit_r(io_hit_r)
    );
    // compare and count
    task automatic chk(input logic [7:0] g, e);
        n_checks++;
        miscompares += int'(g !== e);
        if (g !== e) $display("MISMATCH t=%0t data %h expected %h", $time, g, e);
    endtask
    // core register cycle; read data is registered, so take it a half cycle on
    task automatic sfr(input logic wr, input logic [7:0] a, d);
        @(negedge clk);
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {wr, !wr, a, d};
        @(negedge clk);
        {sfr_wr, sfr_rd} = 2'h0;
        got = sfr_rdata_r;
    endtask
    // window cycle; pointer mode loads the low pointer byte equal to the offset
    task automatic xd(input logic dp, wr, input logic [7:0] a, d);
        if (dp)
            sfr(1'h1, 8'h82, a);
        @(negedge clk);
        {xd_wr, xd_rd, xd_use_data_pointer, xd_low_addr, xd_wdata} = {wr, !wr, dp, a, d};
        @(negedge clk);
        {xd_wr, xd_rd} = 2'h0;
        {got, hit} = {xd_rdata_r, xd_hit_r};
    endtask
    // closing report
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #80000;
        miscompares++;
        give_verdict();
    end
    // reset, table of plain accesses, then the awkward cases
    initial begin
        repeat (16) @(negedge clk);
        reset = 1'h0;
        chk(rst_mix | {7'h00, host_data_full_r}, 8'h00);
        foreach (rows[i]) begin
            for (int w = 1; w >= 0; w--)
                if (rows[i].kind == 2'h0)
                    sfr(w[0], rows[i].addr, rows[i].wd);
                else
                    xd(rows[i].kind[1], w[0], rows[i].addr, rows[i].wd);
            chk(got, rows[i].exp);
        end
        $display("test reset and table done");
        u_host.access(1'h1, 16'h0064, 8'hD2, got, hit);
        chk({7'h00, host_data_full_r}, 8'h01);
        xd(1'h0, 1'h0, 8'hF1, 8'h00);
        chk(got, 8'hD2);
        chk({7'h00, hit}, 8'h01);
        chk({7'h00, host_data_full_r}, 8'h00);
        xd(1'h0, 1'h1, 8'hF1, 8'h4A);
        u_host.access(1'h0, 16'h0060, 8'h00, got, hit);
        chk(got | {7'h00, hit}, 8'h4B);
        u_host.access(1'h0, 16'h0082, 8'h00, got, hit);
        chk({7'h00, hit}, 8'h00);
        // host-only clock/CMOS value port, reached by direct address
        u_host.access(1'h1, 16'h0071, 8'h5C, got, hit);
        u_host.access(1'h0, 16'h0071, 8'h00, got, hit);
        chk(got, 8'h5C);
        chk({7'h00, hit}, 8'h01);
        $display("test host done");
        sfr(1'h1, 8'hA0, 8'h7E);
        xd(1'h0, 1'h1, 8'hF4, 8'hFF);
        xd(1'h0, 1'h0, 8'hF4, 8'h00);
        chk(got | {7'h00, hit} | configuration_zero_r ^ 8'hA5, 8'h00);
        sfr(1'h1, 8'h80, 8'h11);
        @(negedge clk);
        {ext_bus_load, ext_bus_byte} = {1'h1, 8'hAA};
        @(negedge clk);
        ext_bus_load = 1'h0;
        sfr(1'h0, 8'h80, 8'h00);
        chk(got, 8'hAA);
        reset = 1'h1;
        @(negedge clk);
        reset = 1'h0;
        chk(rst_mix, 8'h00);
        $display("test refusals and second reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
